// [include/rtp_pkg.sv]
// constants, field layouts and carrier types of the real-time counter with periodic timer
//
// What this block does
// - sixteen-bit counter compared to period and compare
// - compare flag and event after count equals compare
// - overflow flag and event after count equals period
// - overflow loads zero instead of incrementing
// - four selectable reference clock sources
// - power-of-two prescaler up to fifteen bits
// - periodic timer tick every 4 to 32768 periods
// - counter and periodic timer enabled independently
// - one selected timebase feeds both functions
// - debug halt stops counting unless run-while-halted
// - separate enables gate only their own request
// - counter runs while enable bit is one
// - eight free-running periodic events, 8192 down to 64
// - flag set on event, request while flag and enable
// - busy flag per register while write crosses
// - counter runs in standby only if allowed
package rtp_pkg;

    // widths
    localparam int CNT_W = 16;
    localparam int PRESC_W = 15;
    localparam int SHIFT_W = 4;
    localparam int PIT_W = 15;
    localparam int PIT_EVT_N = 8;
    localparam int ULP_DIV_W = 5;

    // reference clock source codes
    localparam logic [1:0] SRC_XTAL = 2'h0;
    localparam logic [1:0] SRC_EXT = 2'h1;
    localparam logic [1:0] SRC_ULP = 2'h2;
    localparam logic [1:0] SRC_ULP32 = 2'h3;

    // oscillator divided by 32: last state of a five-bit divider
    localparam logic [ULP_DIV_W-1:0] ULP_DIV_LAST = 5'h1F;

    // periodic timer: period code n selects 2^(n+2) timebase periods
    localparam logic [4:0] PIT_SHIFT_OFS = 5'h02;
    localparam logic [3:0] PIT_SEL_MAX = 4'hD;
    // event 0 repeats every 2^13 periods, each next event halves it
    localparam int PIT_EVT0_SHIFT = 13;

    // reset values
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] PER_RESET = 16'hFFFF;
    localparam logic [CNT_W-1:0] CMP_RESET = 16'h0000;

    // counter control word
    typedef struct packed {
        logic runStandby;
        logic [SHIFT_W-1:0] presc;
        logic enable;
    } rtp_ctrl_s;

    // periodic timer control word
    typedef struct packed {
        logic [3:0] period;
        logic enable;
    } rtp_pit_s;

    // write-crossing busy flags
    typedef struct packed {
        logic periodic_tick_timer;
        logic cmp;
        logic per;
        logic cnt;
        logic ctrl;
    } rtp_busy_s;

    localparam rtp_ctrl_s CTRL_RESET = '{runStandby: 1'b0, presc: 4'h0, enable: 1'b0};
    localparam rtp_pit_s PIT_RESET = '{period: 4'h0, enable: 1'b0};

endpackage

// [rtl/rtp_pin_sync.sv]
// three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
module rtp_pin_sync (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // asynchronous pin
    input wire logic pinIn,
    // one-cycle pulse on an accepted rising change
    output logic rise
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    logic agree;

    // a change counts only once stages two and three agree
    assign agree = (s2_q == s3_q);
    assign rise = agree && s3_q && !level_q;

    // shift chain and filtered level
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree) begin
                level_q <= s3_q;
            end
        end
    end

endmodule

// [rtl/rtp_prescaler.sv]
// power-of-two prescaler on the timebase tick
`timescale 1ns/1ps
module rtp_prescaler #(
    parameter int WIDTH = 15,
    parameter int SHIFT_W = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // control
    input wire logic clear,
    input wire logic tickIn,
    input wire logic [SHIFT_W-1:0] shift,
    // divided tick, one cycle
    output logic tickOut
);

    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] mask;

    initial begin
        if ((1 << SHIFT_W) - 1 > WIDTH) begin
            $error("prescaler shift range exceeds counter width");
        end
    end

    // divide by 2^shift: pass the tick once the low bits are all ones
    assign mask = ~({WIDTH{1'b1}} << shift);
    assign tickOut = tickIn && ((cnt_q & mask) == mask);

    // free divider, restarted while the counter is disabled
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else if (clear) begin
            cnt_q <= '0;
        end else if (tickIn) begin
            cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule

// [rtl/rtp_top.sv]
// real-time counter with periodic timer, one clock domain, plain control ports
`timescale 1ns/1ps
module rtp_top #(
    parameter int CNT_W = rtp_pkg::CNT_W,
    parameter int PRESC_W = rtp_pkg::PRESC_W
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // reference clock pins
    input wire logic xtalClkIn,
    input wire logic extClkIn,
    input wire logic ulpClkIn,
    // source select, applied directly
    input wire logic [1:0] srcSel,
    // counter control write
    input wire logic ctrlWrite,
    input wire rtp_pkg::rtp_ctrl_s ctrlValue,
    // count, period and compare writes
    input wire logic countWrite,
    input wire logic [CNT_W-1:0] countValue,
    input wire logic periodWrite,
    input wire logic [CNT_W-1:0] periodValue,
    input wire logic compareWrite,
    input wire logic [CNT_W-1:0] compareValue,
    // periodic timer control write
    input wire logic pitWrite,
    input wire rtp_pkg::rtp_pit_s pitValue,
    // interrupt enables
    input wire logic cmpIntEnable,
    input wire logic ovfIntEnable,
    input wire logic pitIntEnable,
    // flag clear pulses
    input wire logic cmpFlagClear,
    input wire logic ovfFlagClear,
    input wire logic pitFlagClear,
    // debug and sleep
    input wire logic debugHalt,
    input wire logic runWhileHalted,
    input wire logic pitRunWhileHalted,
    input wire logic standbySleep,
    // state
    output logic [CNT_W-1:0] countOut,
    output rtp_pkg::rtp_busy_s busy,
    output logic cmpFlag,
    output logic ovfFlag,
    output logic pitFlag,
    // interrupt requests
    output logic cntIrq,
    output logic pitIrq,
    // events, one-cycle pulses
    output logic cmpEvent,
    output logic ovfEvent,
    output logic [rtp_pkg::PIT_EVT_N-1:0] pitEvents
);

    initial begin
        if (CNT_W < 1 || PRESC_W < (1 << rtp_pkg::SHIFT_W) - 1) begin
            $error("counter or prescaler width not supported");
        end
    end

    // ----------------------------------------------------------------
    // timebase selection
    // ----------------------------------------------------------------
    logic xtalRise;
    logic extRise;
    logic ulpRise;
    logic [rtp_pkg::ULP_DIV_W-1:0] ulpDiv_q;
    logic ulp32Tick;
    logic rtcTick;

    rtp_pin_sync u_syncXtal (
        .clock(clock),
        .arst_n(arst_n),
        .pinIn(xtalClkIn),
        .rise(xtalRise)
    );

    rtp_pin_sync u_syncExt (
        .clock(clock),
        .arst_n(arst_n),
        .pinIn(extClkIn),
        .rise(extRise)
    );

    rtp_pin_sync u_syncUlp (
        .clock(clock),
        .arst_n(arst_n),
        .pinIn(ulpClkIn),
        .rise(ulpRise)
    );

    // oscillator divided by 32
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ulpDiv_q <= '0;
        end else if (ulpRise) begin
            ulpDiv_q <= ulpDiv_q + 5'h01;
        end
    end

    // one tick for both functions from the chosen source
    assign ulp32Tick = ulpRise && (ulpDiv_q == rtp_pkg::ULP_DIV_LAST);
    assign rtcTick = (srcSel == rtp_pkg::SRC_XTAL) ? xtalRise :
                     (srcSel == rtp_pkg::SRC_EXT) ? extRise :
                     (srcSel == rtp_pkg::SRC_ULP) ? ulpRise : ulp32Tick;

    // ----------------------------------------------------------------
    // write crossing: shadow, busy, apply at timebase tick
    // ----------------------------------------------------------------
    rtp_pkg::rtp_ctrl_s ctrlSh_q;
    rtp_pkg::rtp_ctrl_s ctrl_q;
    rtp_pkg::rtp_pit_s pitSh_q;
    rtp_pkg::rtp_pit_s pit_q;
    logic [CNT_W-1:0] cntSh_q;
    logic [CNT_W-1:0] perSh_q;
    logic [CNT_W-1:0] per_q;
    logic [CNT_W-1:0] cmpSh_q;
    logic [CNT_W-1:0] cmp_q;
    rtp_pkg::rtp_busy_s busy_q;
    rtp_pkg::rtp_busy_s busyWr;
    rtp_pkg::rtp_busy_s busy_d;

    // a write in the apply cycle keeps its busy bit set
    assign busyWr = '{periodic_tick_timer: pitWrite, cmp: compareWrite, per: periodWrite,
                      cnt: countWrite, ctrl: ctrlWrite};
    assign busy_d = busyWr | (rtcTick ? '0 : busy_q);

    // shadow capture on the bus side
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrlSh_q <= rtp_pkg::CTRL_RESET;
            pitSh_q <= rtp_pkg::PIT_RESET;
            cntSh_q <= rtp_pkg::CNT_RESET;
            perSh_q <= rtp_pkg::PER_RESET;
            cmpSh_q <= rtp_pkg::CMP_RESET;
        end else begin
            if (ctrlWrite) ctrlSh_q <= ctrlValue;
            if (pitWrite) pitSh_q <= pitValue;
            if (countWrite) cntSh_q <= countValue;
            if (periodWrite) perSh_q <= periodValue;
            if (compareWrite) cmpSh_q <= compareValue;
        end
    end

    // pending values take effect on the timebase tick
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= '0;
            ctrl_q <= rtp_pkg::CTRL_RESET;
            pit_q <= rtp_pkg::PIT_RESET;
            per_q <= rtp_pkg::PER_RESET;
            cmp_q <= rtp_pkg::CMP_RESET;
        end else begin
            busy_q <= busy_d;
            if (rtcTick && busy_q.ctrl) ctrl_q <= ctrlSh_q;
            if (rtcTick && busy_q.periodic_tick_timer) pit_q <= pitSh_q;
            if (rtcTick && busy_q.per) per_q <= perSh_q;
            if (rtcTick && busy_q.cmp) cmp_q <= cmpSh_q;
        end
    end

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    logic cntRun;
    logic presTick;
    logic cntStep;
    logic atPeriod;
    logic atCompare;
    logic cntLoad;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    // running: enabled, not held by debug, not stopped in standby
    assign cntRun = ctrl_q.enable
                    && (!debugHalt || runWhileHalted)
                    && (!standbySleep || ctrl_q.runStandby);

    rtp_prescaler #(
        .WIDTH(PRESC_W),
        .SHIFT_W(rtp_pkg::SHIFT_W)
    ) u_presc (
        .clock(clock),
        .arst_n(arst_n),
        .clear(!ctrl_q.enable),
        .tickIn(rtcTick && cntRun),
        .shift(ctrl_q.presc),
        .tickOut(presTick)
    );

    // compare and wrap decode on the present count
    assign cntStep = presTick;
    assign atPeriod = (cnt_q == per_q);
    assign atCompare = (cnt_q == cmp_q);
    assign cntLoad = rtcTick && busy_q.cnt;
    assign cnt_d = cntLoad ? cntSh_q :
                   !cntStep ? cnt_q :
                   atPeriod ? rtp_pkg::CNT_RESET :
                   cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};

    // count register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= rtp_pkg::CNT_RESET;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // periodic timer
    // ----------------------------------------------------------------
    localparam int PIT_W_L = rtp_pkg::PIT_W;
    logic pitRun;
    logic pitStep;
    logic [4:0] pitShift;
    logic [PIT_W_L-1:0] pitMask;
    logic pitHit;
    logic [rtp_pkg::PIT_EVT_N-1:0] pitEvtHit;
    logic [PIT_W_L-1:0] pitCnt_q;

    // runs in every sleep mode, own enable, own debug bit
    assign pitRun = pit_q.enable && (!debugHalt || pitRunWhileHalted);
    assign pitStep = rtcTick && pitRun;
    assign pitShift = {1'b0, pit_q.period} + rtp_pkg::PIT_SHIFT_OFS;
    assign pitMask = ~({PIT_W_L{1'b1}} << pitShift);
    assign pitHit = pitStep && (pit_q.period <= rtp_pkg::PIT_SEL_MAX)
                    && ((pitCnt_q & pitMask) == pitMask);

    // free-running event taps, one per period
    genvar gi;
    generate
        for (gi = 0; gi < rtp_pkg::PIT_EVT_N; gi++) begin : g_evt
            localparam int K = rtp_pkg::PIT_EVT0_SHIFT - gi;
            assign pitEvtHit[gi] = pitStep && (&pitCnt_q[K-1:0]);
        end
    endgenerate

    // periodic timer count, cleared while disabled
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pitCnt_q <= '0;
        end else if (!pit_q.enable) begin
            pitCnt_q <= '0;
        end else if (pitStep) begin
            pitCnt_q <= pitCnt_q + {{(PIT_W_L-1){1'b0}}, 1'b1};
        end
    end

    // ----------------------------------------------------------------
    // flags, requests and events
    // ----------------------------------------------------------------
    logic cmpHit;
    logic ovfHit;
    logic cmpFlag_q;
    logic ovfFlag_q;
    logic pitFlag_q;
    logic cmpFlag_d;
    logic ovfFlag_d;
    logic pitFlag_d;
    logic cntIrq_q;
    logic pitIrq_q;
    logic cmpEvent_q;
    logic ovfEvent_q;
    logic [rtp_pkg::PIT_EVT_N-1:0] pitEvents_q;

    // an event in the clear cycle wins over the clear
    assign cmpHit = cntStep && atCompare && !cntLoad;
    assign ovfHit = cntStep && atPeriod && !cntLoad;
    assign cmpFlag_d = cmpHit || (cmpFlag_q && !cmpFlagClear);
    assign ovfFlag_d = ovfHit || (ovfFlag_q && !ovfFlagClear);
    assign pitFlag_d = pitHit || (pitFlag_q && !pitFlagClear);

    // registered flags, requests and event pulses
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cmpFlag_q <= 1'b0;
            ovfFlag_q <= 1'b0;
            pitFlag_q <= 1'b0;
            cntIrq_q <= 1'b0;
            pitIrq_q <= 1'b0;
            cmpEvent_q <= 1'b0;
            ovfEvent_q <= 1'b0;
            pitEvents_q <= '0;
        end else begin
            cmpFlag_q <= cmpFlag_d;
            ovfFlag_q <= ovfFlag_d;
            pitFlag_q <= pitFlag_d;
            cntIrq_q <= (cmpFlag_d && cmpIntEnable) || (ovfFlag_d && ovfIntEnable);
            pitIrq_q <= pitFlag_d && pitIntEnable;
            cmpEvent_q <= cmpHit;
            ovfEvent_q <= ovfHit;
            pitEvents_q <= pitEvtHit;
        end
    end

    // outputs straight from flops
    assign countOut = cnt_q;
    assign busy = busy_q;
    assign cmpFlag = cmpFlag_q;
    assign ovfFlag = ovfFlag_q;
    assign pitFlag = pitFlag_q;
    assign cntIrq = cntIrq_q;
    assign pitIrq = pitIrq_q;
    assign cmpEvent = cmpEvent_q;
    assign ovfEvent = ovfEvent_q;
    assign pitEvents = pitEvents_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // enables as seen by the request register
    logic cmpIntEnable_d1;
    logic ovfIntEnable_d1;
    always_ff @(posedge clock) begin
        cmpIntEnable_d1 <= cmpIntEnable;
        ovfIntEnable_d1 <= ovfIntEnable;
    end

    a_count_step: assert property (cntStep && !cntLoad && !atPeriod
        |=> cnt_q == $past(cnt_q) + 16'h0001) else $error("count did not step by one");
    a_wrap_zero: assert property (cntStep && !cntLoad && atPeriod
        |=> cnt_q == rtp_pkg::CNT_RESET) else $error("count did not wrap to zero");
    a_ovf_event: assert property (cntStep && !cntLoad && atPeriod
        |=> ovfEvent && ovfFlag) else $error("overflow flag or event missing");
    a_cmp_event: assert property (cmpEvent
        |-> $past(cnt_q) == $past(cmp_q) && $past(presTick)) else $error("compare event stray");
    a_irq_gate: assert property (cntIrq
        |-> (cmpFlag && cmpIntEnable_d1) || (ovfFlag && ovfIntEnable_d1))
        else $error("counter request without enabled flag");
    a_halt_hold: assert property (debugHalt && !runWhileHalted && !busy_q.cnt
        |=> $stable(cnt_q)) else $error("count moved while halted");
    a_disabled_hold: assert property (!ctrl_q.enable && !busy_q.cnt && !busy_q.ctrl && !countWrite
        |=> $stable(cnt_q)[*2]) else $error("count moved while disabled");
    a_busy_apply: assert property (busy_q.per && rtcTick && !periodWrite
        |=> !busy_q.per && per_q == $past(perSh_q)) else $error("period write not applied");
    a_flag_sticky: assert property (pitFlag && !pitFlagClear
        |=> pitFlag) else $error("periodic flag lost without clear");
    a_pit_tap: assert property (pitStep && (&pitCnt_q[5:0])
        |=> pitEvents[7]) else $error("fastest periodic event missing");
    a_pit_sleep: assert property (standbySleep && pitStep
        |=> pitCnt_q != $past(pitCnt_q)) else $error("periodic timer stopped in sleep");

    c_overflow: cover property (ovfEvent);
    c_compare: cover property (cmpEvent);
    c_pit_irq: cover property (pitIrq);
    c_set_on_clear: cover property (ovfHit && ovfFlagClear && ovfFlag_q);

endmodule

// [dv/rtp_ref_clocks.sv]
// slow reference clock sources that feed the counter's pins
`timescale 1ns/1ps
module rtp_ref_clocks #(
    parameter int XTAL_HALF = 240,
    parameter int EXT_HALF = 280,
    parameter int ULP_HALF = 160
) (
    // reference clock pins
    output logic xtalClk,
    output logic extClk,
    output logic ulpClk
);
    // ---------------------------------------------
    // free-running sources, odd phase offsets
    // ---------------------------------------------
    // oscillators run from time zero, before any source select
    initial begin
        xtalClk = 1'b0;
        #7;
        forever #(XTAL_HALF) xtalClk = ~xtalClk;
    end
    initial begin
        extClk = 1'b0;
        #13;
        forever #(EXT_HALF) extClk = ~extClk;
    end
    initial begin
        ulpClk = 1'b0;
        #3;
        forever #(ULP_HALF) ulpClk = ~ulpClk;
    end
endmodule

// [dv/tb_rtp_top.sv]
// self-checking testbench of the real-time counter with periodic timer
`timescale 1ns/1ps
module tb_rtp_top;
    // ---------------------------------------------
    // signals
    // ---------------------------------------------
    logic clock, arst_n, xtal, ext, ulp;
    logic [1:0] srcSel;
    logic [4:0] wrStb;
    logic [15:0] wrVal, countOut, prevCount, expCmp;
    logic cmpIntEnable, ovfIntEnable, pitIntEnable, cmpFlagClear, ovfFlagClear, pitFlagClear;
    logic debugHalt, runWhileHalted, pitRunWhileHalted, standbySleep;
    rtp_pkg::rtp_busy_s busy;
    logic cmpFlag, ovfFlag, pitFlag, cntIrq, pitIrq, cmpEvent, ovfEvent;
    logic [7:0] pitEvents;
    int fail_count, tests_run, stepCount, ovfCount, cmpCount, pitHi, ev7, ev0, g, s;
    int srcGap[4] = '{12, 14, 8, 256};
    logic [4:0] halt[4] = '{5'b10000, 5'b11001, 5'b00100, 5'b00111};

    rtp_ref_clocks refs (.xtalClk(xtal), .extClk(ext), .ulpClk(ulp));

    rtp_top dut (
        .clock(clock), .arst_n(arst_n), .xtalClkIn(xtal), .extClkIn(ext), .ulpClkIn(ulp),
        .srcSel(srcSel), .ctrlWrite(wrStb[0]), .ctrlValue(rtp_pkg::rtp_ctrl_s'(wrVal[5:0])),
        .countWrite(wrStb[1]), .countValue(wrVal), .periodWrite(wrStb[2]),
        .periodValue(wrVal), .compareWrite(wrStb[3]), .compareValue(wrVal),
        .pitWrite(wrStb[4]), .pitValue(rtp_pkg::rtp_pit_s'(wrVal[4:0])),
        .cmpIntEnable(cmpIntEnable), .ovfIntEnable(ovfIntEnable), .pitIntEnable(pitIntEnable),
        .cmpFlagClear(cmpFlagClear), .ovfFlagClear(ovfFlagClear), .pitFlagClear(pitFlagClear),
        .debugHalt(debugHalt), .runWhileHalted(runWhileHalted),
        .pitRunWhileHalted(pitRunWhileHalted), .standbySleep(standbySleep),
        .countOut(countOut), .busy(busy), .cmpFlag(cmpFlag), .ovfFlag(ovfFlag),
        .pitFlag(pitFlag), .cntIrq(cntIrq), .pitIrq(pitIrq), .cmpEvent(cmpEvent),
        .ovfEvent(ovfEvent), .pitEvents(pitEvents)
    );

    // ---------------------------------------------
    // clock, helpers
    // ---------------------------------------------
    // 25 MHz system clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // compare seen and expected, count mismatches
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic complete_run();
        if (fail_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // one write pulse, busy must rise then drop after a tick
    task automatic wr(input int idx, input logic [15:0] v);
        int n;
        @(posedge clock);
        wrStb <= 5'(1 << idx);
        wrVal <= v;
        @(posedge clock);
        wrStb <= 5'h00;
        #1 check(16'(busy[idx]), 16'h0001);
        n = 0;
        while (busy[idx] !== 1'b0 && n < 400) begin
            @(posedge clock);
            #1 n++;
        end
        check(16'(busy[idx]), 16'h0000);
    endtask

    // bounded wait for the next change of a monitor counter
    task automatic wait_on(ref int cnt, output int cyc);
        int m;
        m = cnt;
        cyc = 0;
        while (cnt == m && cyc < 3000) begin
            @(negedge clock);
            cyc++;
        end
    endtask

    // gap within two cycles of the expected figure
    function automatic logic [15:0] near(input int got, input int exp);
        return 16'(got >= exp - 2 && got <= exp + 2);
    endfunction

    // ---------------------------------------------
    // monitor on settled outputs
    // ---------------------------------------------
    always @(negedge clock) begin
        if (countOut !== prevCount)
            stepCount++;
        prevCount = countOut;
        if (ovfEvent === 1'b1)
            ovfCount++;
        if (ovfEvent === 1'b1)
            check(countOut, 16'h0000);
        if (cmpEvent === 1'b1)
            cmpCount++;
        if (cmpEvent === 1'b1)
            check(countOut, expCmp + 16'h0001);
        if (pitFlag === 1'b1)
            pitHi++;
        if (pitEvents[7] === 1'b1)
            ev7++;
        if (pitEvents[0] === 1'b1)
            ev0++;
    end

    // hang guard
    initial begin
        repeat (60000) @(posedge clock);
        fail_count++;
        complete_run();
    end

    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        {arst_n, srcSel, wrStb, wrVal, prevCount, expCmp} = '0;
        {cmpIntEnable, ovfIntEnable, pitIntEnable, cmpFlagClear, ovfFlagClear} = '0;
        {pitFlagClear, debugHalt, runWhileHalted, pitRunWhileHalted, standbySleep} = '0;
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        @(negedge clock);
        check(countOut, 16'h0000);
        check(16'(busy), 16'h0000);
        check(16'({cmpFlag, ovfFlag, pitFlag, cntIrq, pitIrq}), 16'h0000);
        // period 2, compare 1, wrap and both events
        expCmp = 16'h0001;
        wr(2, 16'h0002);
        wr(3, 16'h0001);
        ovfIntEnable <= 1'b1;
        wr(0, 16'h0001);
        repeat (400) @(negedge clock);
        check(16'(ovfCount > 3), 16'h0001);
        check(16'(cmpCount > 3), 16'h0001);
        check(16'({ovfFlag, cmpFlag, cntIrq}), 16'h0007);
        wr(0, 16'h0000);
        repeat (2) @(negedge clock);
        s = stepCount;
        repeat (100) @(negedge clock);
        check(16'(stepCount), 16'(s));
        ovfIntEnable <= 1'b0;
        repeat (2) @(negedge clock);
        check(16'(cntIrq), 16'h0000);
        cmpIntEnable <= 1'b1;
        repeat (2) @(negedge clock);
        check(16'(cntIrq), 16'h0001);
        @(posedge clock);
        {cmpFlagClear, ovfFlagClear} <= 2'b11;
        @(posedge clock);
        {cmpFlagClear, ovfFlagClear} <= 2'b00;
        repeat (2) @(negedge clock);
        check(16'({cmpFlag, ovfFlag, cntIrq}), 16'h0000);
        // prescaler divide by four
        wr(2, 16'hFFFF);
        wr(0, 16'h0005);
        wait_on(stepCount, g);
        wait_on(stepCount, g);
        check(near(g, 48), 16'h0001);
        // every source at prescale one
        wr(0, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            srcSel <= 2'(i);
            wait_on(stepCount, g);
            wait_on(stepCount, g);
            check(near(g, srcGap[i]), 16'h0001);
        end
        srcSel <= 2'h0;
        // debug halt and standby table
        for (int i = 0; i < 4; i++) begin
            wr(0, 16'({halt[i][1], 5'b00001}));
            @(posedge clock);
            {debugHalt, runWhileHalted, standbySleep} <= halt[i][4:2];
            repeat (2) @(negedge clock);
            s = stepCount;
            repeat (150) @(negedge clock);
            check(16'(stepCount != s), 16'(halt[i][0]));
        end
        {debugHalt, runWhileHalted, standbySleep} <= 3'b000;
        // periodic timer with the counter stopped
        wr(0, 16'h0000);
        standbySleep <= 1'b1;
        wr(4, 16'h0001);
        repeat (80) @(negedge clock);
        check(16'({pitFlag, pitIrq}), 16'h0002);
        pitIntEnable <= 1'b1;
        repeat (2) @(negedge clock);
        check(16'(pitIrq), 16'h0001);
        pitFlagClear <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            wr(4, 16'((c << 1) | 1));
            wait_on(pitHi, g);
            wait_on(pitHi, g);
            check(near(g, 48 << c), 16'h0001);
        end
        ev7 = 0;
        ev0 = 0;
        repeat (1700) @(negedge clock);
        check(16'(ev7 inside {2, 3}), 16'h0001);
        check(16'(ev0), 16'h0000);
        // count write lands on the next tick
        wr(1, 16'h1234);
        check(countOut, 16'h1234);
        complete_run();
    end
endmodule
